// ### logic/dfl_char_replace.v
// Receive octet path: receiver disable and end-of-frame character replacement
`timescale 1ns/100ps
`include "dfl_consts.vh"

module dfl_char_replace (
  input wire aclk,
  input wire aresetn,
  input wire core_soft_reset,
  input wire receiver_disable,
  input wire replacement_disable,
  input wire in_valid,
  input wire [7:0] in_data,
  input wire in_is_k,
  input wire in_frame_end,
  input wire in_multiframe_end,
  output reg out_valid,
  output reg [7:0] out_data,
  output reg out_is_k
);

  reg [7:0] last_data;
  reg is_end_char;

  // An /A/ closing a multiframe or an /F/ closing a frame is a replacement candidate
  always @* begin
    is_end_char = in_is_k &
      ((in_multiframe_end & (in_data == `DFL_CHAR_A)) | (in_frame_end & (in_data == `DFL_CHAR_F)));
  end

  // Output stage; the previous octet stands in for a replaced character
  always @(posedge aclk) begin
    if (!aresetn || core_soft_reset) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_is_k <= 1'b0;
      last_data <= 8'h00;
    end else begin
      out_valid <= in_valid & ~receiver_disable;
      if (in_valid && !receiver_disable) begin
        if (is_end_char && !replacement_disable) begin
          out_data <= last_data;
          out_is_k <= 1'b0;
        end else begin
          out_data <= in_data;
          out_is_k <= in_is_k;
          last_data <= in_data;
        end
      end
    end
  end

endmodule

// ### logic/dfl_consts.vh
// Constants for the deframer lane sync status and control block
`ifndef DFL_CONSTS_VH
`define DFL_CONSTS_VH

// Bus widths and responses
`define DFL_ADDR_W 16
`define DFL_DATA_W 32
`define DFL_RESP_OKAY 2'b00
`define DFL_RESP_SLVERR 2'b10

// Register index of the core soft reset register; byte address is four times it
`define DFL_IDX_CORE_RESET 16'h0475
`define DFL_ADDR_CORE_RESET 16'h11d4
// Byte addresses of the remaining registers
`define DFL_ADDR_LANE_SYNC 16'h0000
`define DFL_ADDR_CTRL0 16'h0004
`define DFL_ADDR_LINK_CFG 16'h0008
`define DFL_ADDR_IRQ_STATUS 16'h000c
`define DFL_ADDR_IRQ_MASK 16'h0010

// Decoded register selects
`define DFL_SEL_NONE 3'h0
`define DFL_SEL_LANE_SYNC 3'h1
`define DFL_SEL_CTRL0 3'h2
`define DFL_SEL_LINK_CFG 3'h3
`define DFL_SEL_IRQ_STATUS 3'h4
`define DFL_SEL_IRQ_MASK 3'h5
`define DFL_SEL_CORE_RESET 3'h6

// Field positions
`define DFL_LANES 3
`define DFL_BIT_RECEIVER_DISABLE 7
`define DFL_BIT_REPL_DIS 6
`define DFL_BIT_SKIP_ALIGN 0
`define DFL_BIT_SOFT_RESET 3
`define DFL_IRQ_W 7
`define DFL_IRQ_LOST_LSB 3
`define DFL_BIT_IRQ_REFUSED 6

// Reset values
`define DFL_RST_LANE_SYNC 3'h0
`define DFL_RST_RECEIVER_DISABLE 1'b0
`define DFL_RST_REPL_DIS 1'b0
`define DFL_RST_SKIP_ALIGN 1'b0
`define DFL_RST_SOFT_RESET 1'b1
`define DFL_RST_IRQ 7'h00

// Control characters ending frames and multiframes
`define DFL_CHAR_A 8'h7c
`define DFL_CHAR_F 8'hfc

`endif

// ### logic/dfl_lane_sync.v
// Per-lane initial synchronization flag with achieved and lost event pulses
`timescale 1ns/100ps
`include "dfl_consts.vh"

module dfl_lane_sync (
  input wire aclk,
  input wire aresetn,
  input wire lane_sync_ok,
  input wire core_soft_reset,
  output reg sync_flag,
  output reg sync_achieved,
  output reg sync_lost
);

  // Flag follows the alignment logic, forced low while the core is in soft reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_flag <= 1'b0;
      sync_achieved <= 1'b0;
      sync_lost <= 1'b0;
    end else begin
      sync_flag <= lane_sync_ok & ~core_soft_reset;
      sync_achieved <= lane_sync_ok & ~core_soft_reset & ~sync_flag;
      sync_lost <= sync_flag & ~(lane_sync_ok & ~core_soft_reset);
    end
  end

endmodule

// ### logic/dfl_top.v
// Deframer lane sync status and control registers behind an AXI4-Lite slave
// Behaviour
// - Each lane has a read-only sync flag, 1 once initial synchronization is achieved.
// - A lane's sync flag reads 0 while synchronization is lost or not reached.
// - Lane 0 to 2 sync flags reset to zero and are read-only.
// - receiver_disable, control bit 7, disables the receiver as a level while 1.
// - replacement_disable, bit 6, set to 1 stops /A/ and /F/ replacement.
// - With replacement_disable at 0, end-of-frame /A/ and /F/ characters are substituted.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dfl_consts.vh"

module dfl_top (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] lane_sync_ok,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_is_k,
  input wire rx_frame_end,
  input wire rx_multiframe_end,
  output wire deframed_valid,
  output wire [7:0] deframed_data,
  output wire deframed_is_k,
  output reg receiver_disable,
  output reg replacement_disable,
  output reg skip_initial_alignment,
  output reg core_soft_reset,
  output reg irq
);

  // Maps a byte address onto a register select
  function [2:0] dfl_decode;
    input [15:0] addr;
    begin
      if (addr == `DFL_ADDR_LANE_SYNC)
        dfl_decode = `DFL_SEL_LANE_SYNC;
      else if (addr == `DFL_ADDR_CTRL0)
        dfl_decode = `DFL_SEL_CTRL0;
      else if (addr == `DFL_ADDR_LINK_CFG)
        dfl_decode = `DFL_SEL_LINK_CFG;
      else if (addr == `DFL_ADDR_IRQ_STATUS)
        dfl_decode = `DFL_SEL_IRQ_STATUS;
      else if (addr == `DFL_ADDR_IRQ_MASK)
        dfl_decode = `DFL_SEL_IRQ_MASK;
      else if (addr == `DFL_ADDR_CORE_RESET)
        dfl_decode = `DFL_SEL_CORE_RESET;
      else
        dfl_decode = `DFL_SEL_NONE;
    end
  endfunction

  // True when a firing write targets the given register with byte lane 0 enabled
  function dfl_write_hit;
    input fire;
    input [2:0] sel;
    input [2:0] want;
    input [3:0] strb;
    begin
      if (fire && (sel == want) && strb[0])
        dfl_write_hit = 1'b1;
      else
        dfl_write_hit = 1'b0;
    end
  endfunction

  reg [15:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg [6:0] irq_status;
  reg [6:0] irq_mask;
  reg [6:0] next_irq_status;
  reg [31:0] next_rdata;
  reg [2:0] rd_sel;
  reg [2:0] wr_sel;
  wire wr_fire;
  wire ctrl_write;
  wire link_write;
  wire core_write;
  wire mask_write;
  wire status_write;
  wire ctrl_refused;
  wire wr_unmapped;
  wire rd_unmapped;
  wire [6:0] irq_event;
  wire [6:0] irq_pending;
  wire [2:0] lane_flag;
  wire [2:0] lane_achieved;
  wire [2:0] lane_lost;

  // Per-lane flags and their achieved and lost events
  genvar lane;
  generate
    for (lane = 0; lane < `DFL_LANES; lane = lane + 1) begin : g_lane
      dfl_lane_sync u_lane_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .lane_sync_ok(lane_sync_ok[lane]),
        .core_soft_reset(core_soft_reset),
        .sync_flag(lane_flag[lane]),
        .sync_achieved(lane_achieved[lane]),
        .sync_lost(lane_lost[lane])
      );
    end
  endgenerate

  // Receive octet path steered by the two control bits
  dfl_char_replace u_char_replace (
    .aclk(aclk),
    .aresetn(aresetn),
    .core_soft_reset(core_soft_reset),
    .receiver_disable(receiver_disable),
    .replacement_disable(replacement_disable),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_is_k(rx_is_k),
    .in_frame_end(rx_frame_end),
    .in_multiframe_end(rx_multiframe_end),
    .out_valid(deframed_valid),
    .out_data(deframed_data),
    .out_is_k(deframed_is_k)
  );

  // A write fires once both address and data are held and no response is pending
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ctrl_refused = ctrl_write & ~core_soft_reset;

  // Write enables of the individual registers, byte lane 0 only
  assign ctrl_write = dfl_write_hit(wr_fire, wr_sel, `DFL_SEL_CTRL0, wr_strb);
  assign link_write = dfl_write_hit(wr_fire, wr_sel, `DFL_SEL_LINK_CFG, wr_strb);
  assign core_write = dfl_write_hit(wr_fire, wr_sel, `DFL_SEL_CORE_RESET, wr_strb);
  assign mask_write = dfl_write_hit(wr_fire, wr_sel, `DFL_SEL_IRQ_MASK, wr_strb);
  assign status_write = dfl_write_hit(wr_fire, wr_sel, `DFL_SEL_IRQ_STATUS, wr_strb);

  // Unmapped addresses answer SLVERR on both channels
  assign wr_unmapped = (wr_sel == `DFL_SEL_NONE);
  assign rd_unmapped = (rd_sel == `DFL_SEL_NONE);

  // Events: refused control write, lanes lost, lanes achieved; pending ones pass the mask
  assign irq_event = {ctrl_refused, lane_lost, lane_achieved};
  assign irq_pending = next_irq_status & irq_mask;

  // Write address decode
  always @* begin
    wr_sel = dfl_decode(wr_addr);
  end

  // Write address and data channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wr_addr <= 16'h0000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DFL_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_unmapped)
        s_axi_bresp <= `DFL_RESP_SLVERR;
      else
        s_axi_bresp <= `DFL_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control bits; changes outside soft reset are refused
  always @(posedge aclk) begin
    if (!aresetn) begin
      receiver_disable <= `DFL_RST_RECEIVER_DISABLE;
      replacement_disable <= `DFL_RST_REPL_DIS;
    end else if (ctrl_write && core_soft_reset) begin
      receiver_disable <= wr_data[`DFL_BIT_RECEIVER_DISABLE];
      replacement_disable <= wr_data[`DFL_BIT_REPL_DIS];
    end
  end

  // Link configuration: skip of the initial alignment sequence
  always @(posedge aclk) begin
    if (!aresetn)
      skip_initial_alignment <= `DFL_RST_SKIP_ALIGN;
    else if (link_write)
      skip_initial_alignment <= wr_data[`DFL_BIT_SKIP_ALIGN];
  end

  // Core soft reset, held from power-up until software releases it
  always @(posedge aclk) begin
    if (!aresetn)
      core_soft_reset <= `DFL_RST_SOFT_RESET;
    else if (core_write)
      core_soft_reset <= wr_data[`DFL_BIT_SOFT_RESET];
  end

  // Interrupt mask, same layout as the event status
  always @(posedge aclk) begin
    if (!aresetn)
      irq_mask <= `DFL_RST_IRQ;
    else if (mask_write)
      irq_mask <= wr_data[`DFL_IRQ_W-1:0];
  end

  // Sticky event bits: write one to clear, a new event in the same cycle wins
  always @* begin
    next_irq_status = irq_status;
    if (status_write)
      next_irq_status = irq_status & ~wr_data[`DFL_IRQ_W-1:0];
    next_irq_status = next_irq_status | irq_event;
  end

  // Event status register
  always @(posedge aclk) begin
    if (!aresetn)
      irq_status <= `DFL_RST_IRQ;
    else
      irq_status <= next_irq_status;
  end

  // Interrupt level, high while an unmasked event bit is set
  always @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |irq_pending;
  end

  // Read data mux; reserved bits read as zero
  always @* begin
    rd_sel = dfl_decode(s_axi_araddr);
    next_rdata = 32'h00000000;
    case (rd_sel)
      `DFL_SEL_LANE_SYNC: next_rdata[`DFL_LANES-1:0] = lane_flag;
      `DFL_SEL_CTRL0: begin
        next_rdata[`DFL_BIT_RECEIVER_DISABLE] = receiver_disable;
        next_rdata[`DFL_BIT_REPL_DIS] = replacement_disable;
      end
      `DFL_SEL_LINK_CFG: next_rdata[`DFL_BIT_SKIP_ALIGN] = skip_initial_alignment;
      `DFL_SEL_IRQ_STATUS: next_rdata[`DFL_IRQ_W-1:0] = irq_status;
      `DFL_SEL_IRQ_MASK: next_rdata[`DFL_IRQ_W-1:0] = irq_mask;
      `DFL_SEL_CORE_RESET: next_rdata[`DFL_BIT_SOFT_RESET] = core_soft_reset;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DFL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      if (rd_unmapped)
        s_axi_rresp <= `DFL_RESP_SLVERR;
      else
        s_axi_rresp <= `DFL_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### sim/deframer_lane_sync_status_ctrl_bench.sv
// Register and octet path tests for the deframer status and control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module deframer_lane_sync_status_ctrl_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid, rx_is_k, rx_frame_end, rx_multiframe_end;
  logic deframed_valid, deframed_is_k, receiver_disable, replacement_disable, skip_initial_alignment;
  logic core_soft_reset, irq, start;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [2:0] s_axi_awprot, s_axi_arprot, lane_sync_ok, lanes_up;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] rx_data, deframed_data, lo;
  int err_count, n_tests, cyc, nv, nk;
  logic [7:0] ctl [3] = '{8'h40, 8'h00, 8'h80};
  int ev [3] = '{4, 4, 0};
  int ek [3] = '{2, 0, 0};
  logic [7:0] ed [3] = '{8'hfc, 8'h22, 8'h00};
  dfl_top DUT (.*);
  dfl_link_tx u_tx (.*);
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  // Watchdog and count of octets leaving the deframer
  always @(posedge aclk) begin
    cyc++;
    if (deframed_valid) nv++;
    if (deframed_valid && deframed_is_k) nk++;
    if (deframed_valid) lo = deframed_data;
    if (cyc == 6000) begin
      err_count++;
      conclude();
    end
  end
  task conclude;
    begin
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task axw(input [15:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task axr(input [15:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // Main sequence: reset values, lane flags, interrupt, refusal, octet path
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, start} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = 0;
    s_axi_wstrb = 4'hf;
    lanes_up = 3'h5;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(16'h0000);
    `CHK("lane_sync", 32'h0, rd)
    axr(16'h11d4);
    `CHK("core_reset", 32'h8, rd)
    axw(16'h11d4, 32'h0);
    repeat (4) @(posedge aclk);
    `CHK("skip", 1'b0, skip_initial_alignment)
    axw(16'h0008, 32'h1);
    `CHK("skip", 1'b1, skip_initial_alignment)
    axw(16'h0008, 32'h0);
    axr(16'h0000);
    `CHK("lane_sync", 32'h5, rd)
    lanes_up <= 3'h4;
    repeat (4) @(posedge aclk);
    axr(16'h0000);
    `CHK("lane_sync", 32'h4, rd)
    axw(16'h0000, 32'h7);
    axr(16'h0000);
    `CHK("lane_sync", 32'h4, rd)
    axw(16'h0020, 32'h1);
    `CHK("unmapped_wresp", 2'b10, rs)
    `CHK("irq", 1'b0, irq)
    axw(16'h0010, 32'h8);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    axw(16'h000c, 32'h3f);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    axw(16'h0004, 32'hc0);
    axr(16'h0004);
    `CHK("ctrl0", 32'h0, rd)
    axr(16'h000c);
    `CHK("irq_status", 32'h40, rd)
    axr(16'h0020);
    `CHK("unmapped_resp", 2'b10, rs)
    `CHK("unmapped_data", 32'h0, rd)
    for (int i = 0; i < 3; i++) begin
      axw(16'h11d4, 32'h8);
      axw(16'h0004, {24'h0, ctl[i]});
      axr(16'h0004);
      `CHK("ctrl0", {24'h0, ctl[i]}, rd)
      axw(16'h11d4, 32'h0);
      nv = 0;
      nk = 0;
      lo = 8'h00;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      repeat (8) @(posedge aclk);
      `CHK("rx_disable", ctl[i][7], receiver_disable)
      `CHK("octets", ev[i], nv)
      `CHK("k_octets", ek[i], nk)
      `CHK("repl_disable", ctl[i][6], replacement_disable)
      `CHK("last_octet", ed[i], lo)
    end
    // Second reset in mid-run: control bits and flags return to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(16'h11d4);
    `CHK("core_reset", 32'h8, rd)
    `CHK("soft_reset", 1'b1, core_soft_reset)
    axr(16'h0004);
    `CHK("ctrl0", 32'h0, rd)
    axr(16'h0000);
    `CHK("lane_sync", 32'h0, rd)
    conclude();
  end
endmodule

// ### sim/dfl_link_tx.sv
// Link transmitter model feeding lane sync levels and a short octet frame
`timescale 1ns/100ps
module dfl_link_tx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] lanes_up,
  input wire logic start,
  output logic [2:0] lane_sync_ok,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_is_k,
  output logic rx_frame_end,
  output logic rx_multiframe_end
);
  logic [2:0] idx;
  logic [7:0] idle = 8'h00;
  // Lane levels follow the request; frame steps through four octets
  always @(posedge aclk) begin
    lane_sync_ok <= aresetn ? lanes_up : 3'h0;
    idle <= idle + 8'h35;
    if (!aresetn)
      idx <= 3'h0;
    else if (start)
      idx <= 3'h1;
    else if (idx != 3'h0)
      idx <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
  end
  // Idle octet lines toggle so stale data is never mistaken for a valid octet
  assign rx_valid = (idx != 3'h0);
  assign rx_data = (idx == 3'h1) ? 8'h11 : (idx == 3'h2) ? 8'h22 : (idx == 3'h3) ? 8'h7c : (idx == 3'h4) ? 8'hfc : idle;
  assign rx_is_k = (idx >= 3'h3);
  assign rx_multiframe_end = (idx == 3'h3);
  assign rx_frame_end = (idx == 3'h4);
endmodule

// ### sim/dfl_top_sva.sv
// Port checker for the deframer status and control block
`timescale 1ns/100ps
module dfl_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_is_k,
  input wire logic rx_frame_end,
  input wire logic deframed_valid,
  input wire logic [7:0] deframed_data,
  input wire logic deframed_is_k,
  input wire logic receiver_disable,
  input wire logic replacement_disable,
  input wire logic core_soft_reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire live = !receiver_disable && !core_soft_reset;
  rx_block_a: assert property (receiver_disable |=> !deframed_valid) else $error("octet passed while disabled");
  rx_pass_a: assert property (rx_valid && live |=> deframed_valid) else $error("octet dropped");
  data_pass_a: assert property (rx_valid && !rx_is_k && live
    |=> deframed_data == $past(rx_data) && !deframed_is_k) else $error("data octet altered");
  repl_off_a: assert property (rx_valid && rx_is_k && replacement_disable && live
    |=> deframed_is_k && deframed_data == $past(rx_data)) else $error("control octet replaced");
  repl_on_a: assert property (rx_valid && rx_is_k && rx_data == 8'hfc && rx_frame_end
    && !replacement_disable && live |=> !deframed_is_k) else $error("frame end not replaced");
  ctrl_lock_a: assert property (!core_soft_reset |=> $stable({receiver_disable, replacement_disable}))
    else $error("control changed outside soft reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
  cover property (receiver_disable && rx_valid);
  cover property (deframed_valid && deframed_is_k);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind dfl_top dfl_top_chk u_chk (.*);
